/* include/ssr_pkg.sv */
// Purpose: constants for the system-control soft reset and raw event slice
// Assumes: 32-bit APB, byte addresses as printed
// Notes:   single clock domain
package ssr_pkg;
    localparam logic [11:0] OFF_SOFT_RESET_0 = 12'h040;
    localparam logic [11:0] OFF_SOFT_RESET_1 = 12'h044;
    localparam logic [11:0] OFF_PORT_RESET   = 12'h048;
    localparam logic [11:0] OFF_RAW_STATUS   = 12'h050;
    localparam logic [11:0] OFF_EVENT_MASK   = 12'h054;
    localparam logic [11:0] OFF_MASKED_CLR   = 12'h058;
    localparam logic [11:0] OFF_BROWNOUT_CTL = 12'h030;
    // implemented bits of each reset register
    localparam logic [31:0] SR0_BITS  = 32'h0011_0008;
    localparam logic [31:0] SR1_BITS  = 32'h0107_0013;
    localparam logic [31:0] PORT_BITS = 32'h0000_001F;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;
    localparam int SR0_PWM = 20;
    localparam int SR0_ADC = 16;
    localparam int SR0_WDT = 3;
    localparam int EVT_W        = 7;
    localparam int EVT_PLL_LOCK = 6;
    localparam int EVT_CUR_LIM  = 5;
    localparam int EVT_IOSC     = 4;
    localparam int EVT_MOSC     = 3;
    localparam int EVT_LDO      = 2;
    localparam int EVT_BROWNOUT = 1;
    localparam int EVT_PLL_FLT  = 0;
    localparam int BOR_SEL_BIT  = 1;
endpackage

/* logic/ssr_sysctl.sv */
// Purpose: soft reset registers, raw event status, mask and interrupt
// Assumes: event inputs are synchronous pulses or levels from on-chip monitors
// Notes:   only brown-out reset-select bit of its control register is kept here
`timescale 1ns/100ps
// Functional notes
// - writes to reset register 0 only change bits present in capability 1
// - writes to reset register 1 only change bits present in capability 2
// - writes to port reset register only change bits present in capability 4
// - reset reg 0: bit 20 pwm, 16 converter, 3 watchdog, reset 0
// - reset reg 1: bit 24 comparator, 18..16 timers two..zero, reset 0
// - reset reg 1: bit 4 sync serial, 1 serial one, 0 serial zero
// - port reset register bits 0..4 for ports a..e, reset 0
// - reserved bits read only; here they read zero, writes ignored
// - raw status read only, reset 0, set by hardware, cleared only by w1c to masked status
// - raw bit 6 set when pll ready timer asserts
// - raw bit 5 set when regulator current limit asserts
// - raw bit 4 internal oscillator fault, bit 3 main oscillator fault
// - raw bit 2 set when regulator output unregulated
// - raw bit 1 any brown-out; irq only with mask set, select clear
// - raw bit 0 set when pll stops oscillating
// - brown-out select 1 signals reset, 0 signals interrupt
// - interrupt only when both mask bit and raw bit are set
// - write one to masked status clears it and the raw bit
module ssr_sysctl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] capability_reg_1,
    input  wire logic [31:0] capability_reg_2,
    input  wire logic [31:0] capability_reg_4,
    input  wire logic        pll_ready_evt,
    input  wire logic        current_limit_evt,
    input  wire logic        internal_osc_fault_evt,
    input  wire logic        main_osc_fault_evt,
    input  wire logic        regulator_unreg_evt,
    input  wire logic        brownout_evt,
    input  wire logic        pll_fault_evt,
    output logic [31:0]      periph_reset_0,
    output logic [31:0]      periph_reset_1,
    output logic [31:0]      port_reset,
    output logic             sys_irq,
    output logic             brownout_reset_req
);
    // -------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------
    logic              wr_en;
    logic              rd_en;
    logic [31:0]       periph_soft_reset_0_ff;
    logic [31:0]       periph_soft_reset_1_ff;
    logic [31:0]       port_soft_reset_ff;
    logic [6:0]        sys_event_raw_status_ff;
    logic [6:0]        sys_event_mask_reg_ff;
    logic              brownout_reset_select_ff;
    logic [6:0]        evt_in;
    logic [6:0]        w1c_clr;
    logic [6:0]        nxt_raw;
    logic [31:0]       nxt_rdata;
    logic              nxt_err;
    logic              mapped;

    // zero wait state: access phase always completes in one cycle
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    always_comb begin
        mapped = (paddr == ssr_pkg::OFF_SOFT_RESET_0) || (paddr == ssr_pkg::OFF_SOFT_RESET_1)
              || (paddr == ssr_pkg::OFF_PORT_RESET) || (paddr == ssr_pkg::OFF_RAW_STATUS)
              || (paddr == ssr_pkg::OFF_EVENT_MASK) || (paddr == ssr_pkg::OFF_MASKED_CLR)
              || (paddr == ssr_pkg::OFF_BROWNOUT_CTL);
        nxt_err = !mapped;
        nxt_rdata = 32'h0000_0000;
        // reserved bits read as zero
        unique case (paddr)
            ssr_pkg::OFF_SOFT_RESET_0: nxt_rdata = periph_soft_reset_0_ff;
            ssr_pkg::OFF_SOFT_RESET_1: nxt_rdata = periph_soft_reset_1_ff;
            ssr_pkg::OFF_PORT_RESET:   nxt_rdata = port_soft_reset_ff;
            ssr_pkg::OFF_RAW_STATUS:   nxt_rdata = {25'h0, sys_event_raw_status_ff};
            ssr_pkg::OFF_EVENT_MASK:   nxt_rdata = {25'h0, sys_event_mask_reg_ff};
            ssr_pkg::OFF_MASKED_CLR: begin
                nxt_rdata = {25'h0, sys_event_raw_status_ff & sys_event_mask_reg_ff};
            end
            ssr_pkg::OFF_BROWNOUT_CTL: begin
                nxt_rdata = {30'h0, brownout_reset_select_ff, 1'b0};
            end
            default:                   nxt_rdata = 32'h0000_0000;
        endcase
    end

    // read data registered in setup, so prdata is a flop output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd_en || (psel && !penable)) begin
            prdata  <= rd_en ? nxt_rdata : 32'h0000_0000;
            pslverr <= nxt_err;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // -------------------------------------------------------------
    // soft reset registers
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_soft_reset_0_ff <= ssr_pkg::RESET_VAL;
            periph_soft_reset_1_ff <= ssr_pkg::RESET_VAL;
            port_soft_reset_ff     <= ssr_pkg::RESET_VAL;
        end else if (wr_en) begin
            if (paddr == ssr_pkg::OFF_SOFT_RESET_0) begin
                periph_soft_reset_0_ff <= ((pwdata & capability_reg_1)
                    | (periph_soft_reset_0_ff & ~capability_reg_1)) & ssr_pkg::SR0_BITS;
            end
            if (paddr == ssr_pkg::OFF_SOFT_RESET_1) begin
                periph_soft_reset_1_ff <= ((pwdata & capability_reg_2)
                    | (periph_soft_reset_1_ff & ~capability_reg_2)) & ssr_pkg::SR1_BITS;
            end
            if (paddr == ssr_pkg::OFF_PORT_RESET) begin
                port_soft_reset_ff <= ((pwdata & capability_reg_4)
                    | (port_soft_reset_ff & ~capability_reg_4)) & ssr_pkg::PORT_BITS;
            end
        end
    end

    // reset outputs are registered copies of the register bits, one cycle behind; high holds in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_reset_0 <= 32'h0000_0000;
            periph_reset_1 <= 32'h0000_0000;
            port_reset     <= 32'h0000_0000;
        end else begin
            periph_reset_0 <= periph_soft_reset_0_ff;
            periph_reset_1 <= periph_soft_reset_1_ff;
            port_reset     <= port_soft_reset_ff;
        end
    end

    // -------------------------------------------------------------
    // mask and brown-out select
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_event_mask_reg_ff    <= 7'h00;
            brownout_reset_select_ff <= 1'b0;
        end else if (wr_en) begin
            if (paddr == ssr_pkg::OFF_EVENT_MASK) begin
                sys_event_mask_reg_ff <= pwdata[6:0];
            end
            if (paddr == ssr_pkg::OFF_BROWNOUT_CTL) begin
                brownout_reset_select_ff <= pwdata[ssr_pkg::BOR_SEL_BIT];
            end
        end
    end

    // -------------------------------------------------------------
    // raw event status
    // -------------------------------------------------------------
    always_comb begin
        evt_in = 7'h00;
        evt_in[ssr_pkg::EVT_PLL_LOCK] = pll_ready_evt;
        evt_in[ssr_pkg::EVT_CUR_LIM]  = current_limit_evt;
        evt_in[ssr_pkg::EVT_IOSC]     = internal_osc_fault_evt;
        evt_in[ssr_pkg::EVT_MOSC]     = main_osc_fault_evt;
        evt_in[ssr_pkg::EVT_LDO]      = regulator_unreg_evt;
        evt_in[ssr_pkg::EVT_BROWNOUT] = brownout_evt;
        evt_in[ssr_pkg::EVT_PLL_FLT]  = pll_fault_evt;
        w1c_clr = (wr_en && paddr == ssr_pkg::OFF_MASKED_CLR)
                ? (pwdata[6:0] & sys_event_mask_reg_ff) : 7'h00;
        // new event wins over a clear in the same cycle
        nxt_raw = (sys_event_raw_status_ff & ~w1c_clr) | evt_in;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_event_raw_status_ff <= 7'h00;
        end else begin
            sys_event_raw_status_ff <= nxt_raw;
        end
    end

    // -------------------------------------------------------------
    // interrupt and brown-out reset
    // -------------------------------------------------------------
    logic [6:0] irq_src;
    always_comb begin
        irq_src = sys_event_raw_status_ff & sys_event_mask_reg_ff;
        // brown-out routed to reset instead when select is set
        irq_src[ssr_pkg::EVT_BROWNOUT] = irq_src[ssr_pkg::EVT_BROWNOUT]
                                       & !brownout_reset_select_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_irq            <= 1'b0;
            brownout_reset_req <= 1'b0;
        end else begin
            sys_irq            <= |irq_src;
            brownout_reset_req <= brownout_reset_select_ff
                               && sys_event_raw_status_ff[ssr_pkg::EVT_BROWNOUT];
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_sr0_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_SOFT_RESET_0) |=>
        ((periph_soft_reset_0_ff ^ $past(periph_soft_reset_0_ff)) & ~$past(capability_reg_1)) == 0)
        else $error("reset reg 0 changed an absent bit");
    a_sr1_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_SOFT_RESET_1) |=>
        ((periph_soft_reset_1_ff ^ $past(periph_soft_reset_1_ff)) & ~$past(capability_reg_2)) == 0)
        else $error("reset reg 1 changed an absent bit");
    a_port_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_PORT_RESET && pwdata[0] && capability_reg_4[0])
        |=> port_soft_reset_ff[0])
        else $error("port a reset bit did not take write");
    a_sr0_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (periph_soft_reset_0_ff & ~ssr_pkg::SR0_BITS) == 0)
        else $error("reserved bit set in reset reg 0");
    a_sr1_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (periph_soft_reset_1_ff & ~ssr_pkg::SR1_BITS) == 0)
        else $error("reserved bit set in reset reg 1");
    a_evt_sets: assert property (@(posedge clk) disable iff (!rst_n)
        pll_ready_evt |=> sys_event_raw_status_ff[ssr_pkg::EVT_PLL_LOCK])
        else $error("pll lock event lost");
    a_bor_route: assert property (@(posedge clk) disable iff (!rst_n)
        (sys_event_raw_status_ff[ssr_pkg::EVT_BROWNOUT] && brownout_reset_select_ff)
        |=> brownout_reset_req)
        else $error("brown-out reset not signalled");
    a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 sys_irq == $past(|irq_src))
        else $error("interrupt does not follow masked status");
    a_w1c_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (w1c_clr[0] && !pll_fault_evt) |=> !sys_event_raw_status_ff[0])
        else $error("w1c did not clear raw bit");

    // -------------------------------------------------------------
    // reset register checks
    // -------------------------------------------------------------
    a_sr2_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (port_soft_reset_ff & ~ssr_pkg::PORT_BITS) == 0)
        else $error("reserved bit set in port reset reg");
    a_sr2_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_PORT_RESET) |=>
        ((port_soft_reset_ff ^ $past(port_soft_reset_ff)) & ~$past(capability_reg_4)) == 0)
        else $error("port reset reg changed an absent bit");
    a_sr0_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_SOFT_RESET_0) |=>
        ((periph_soft_reset_0_ff ^ $past(pwdata)) & $past(capability_reg_1)
            & ssr_pkg::SR0_BITS) == 0)
        else $error("reset reg 0 did not take present bits");
    a_sr1_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_SOFT_RESET_1) |=>
        ((periph_soft_reset_1_ff ^ $past(pwdata)) & $past(capability_reg_2)
            & ssr_pkg::SR1_BITS) == 0)
        else $error("reset reg 1 did not take present bits");
    a_sr2_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_PORT_RESET) |=>
        ((port_soft_reset_ff ^ $past(pwdata)) & $past(capability_reg_4)
            & ssr_pkg::PORT_BITS) == 0)
        else $error("port reset reg did not take present bits");
    // a bit that drifts between writes drops a peripheral in or out of reset
    a_sr0_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_en && paddr == ssr_pkg::OFF_SOFT_RESET_0) |=> $stable(periph_soft_reset_0_ff))
        else $error("reset reg 0 moved without a write");
    a_sr1_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_en && paddr == ssr_pkg::OFF_SOFT_RESET_1) |=> $stable(periph_soft_reset_1_ff))
        else $error("reset reg 1 moved without a write");
    a_sr2_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_en && paddr == ssr_pkg::OFF_PORT_RESET) |=> $stable(port_soft_reset_ff))
        else $error("port reset reg moved without a write");
    a_out_copy: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> {periph_reset_0, periph_reset_1, port_reset}
            == $past({periph_soft_reset_0_ff, periph_soft_reset_1_ff, port_soft_reset_ff}))
        else $error("reset outputs do not follow registers");

    // -------------------------------------------------------------
    // bus checks
    // -------------------------------------------------------------
    // no wait states: a master waiting on pready sees it right after setup
    a_ready_setup: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && !penable) |=> pready)
        else $error("pready missing after setup");
    a_ready_only: assert property (@(posedge clk) disable iff (!rst_n)
        !(psel && !penable) |=> !pready)
        else $error("pready outside access cycle");
    a_err_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && !penable && !mapped) |=> pslverr)
        else $error("unmapped address gave no error");
    a_sr0_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
        (pready && paddr == ssr_pkg::OFF_SOFT_RESET_0) |-> (prdata & ~ssr_pkg::SR0_BITS) == 0)
        else $error("reserved bits of reset reg 0 read nonzero");
    a_sr1_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
        (pready && paddr == ssr_pkg::OFF_SOFT_RESET_1) |-> (prdata & ~ssr_pkg::SR1_BITS) == 0)
        else $error("reserved bits of reset reg 1 read nonzero");
    a_sr2_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
        (pready && paddr == ssr_pkg::OFF_PORT_RESET) |-> (prdata & ~ssr_pkg::PORT_BITS) == 0)
        else $error("reserved bits of port reset reg read nonzero");
    a_raw_read: assert property (@(posedge clk) disable iff (!rst_n)
        (pready && !pwrite && paddr == ssr_pkg::OFF_RAW_STATUS)
        |-> prdata == {25'h0, $past(sys_event_raw_status_ff)})
        else $error("raw status read wrong");
    a_masked_read: assert property (@(posedge clk) disable iff (!rst_n)
        (pready && !pwrite && paddr == ssr_pkg::OFF_MASKED_CLR)
        |-> prdata == {25'h0, $past(sys_event_raw_status_ff & sys_event_mask_reg_ff)})
        else $error("masked status read wrong");

    // -------------------------------------------------------------
    // raw event checks
    // -------------------------------------------------------------
    a_cur_lim_sets: assert property (@(posedge clk) disable iff (!rst_n)
        current_limit_evt |=> sys_event_raw_status_ff[ssr_pkg::EVT_CUR_LIM])
        else $error("current limit event lost");
    a_iosc_sets: assert property (@(posedge clk) disable iff (!rst_n)
        internal_osc_fault_evt |=> sys_event_raw_status_ff[ssr_pkg::EVT_IOSC])
        else $error("internal oscillator fault lost");
    a_mosc_sets: assert property (@(posedge clk) disable iff (!rst_n)
        main_osc_fault_evt |=> sys_event_raw_status_ff[ssr_pkg::EVT_MOSC])
        else $error("main oscillator fault lost");
    a_ldo_sets: assert property (@(posedge clk) disable iff (!rst_n)
        regulator_unreg_evt |=> sys_event_raw_status_ff[ssr_pkg::EVT_LDO])
        else $error("regulator unregulated event lost");
    a_bor_sets: assert property (@(posedge clk) disable iff (!rst_n)
        brownout_evt |=> sys_event_raw_status_ff[ssr_pkg::EVT_BROWNOUT])
        else $error("brown-out event lost");
    a_pllf_sets: assert property (@(posedge clk) disable iff (!rst_n)
        pll_fault_evt |=> sys_event_raw_status_ff[ssr_pkg::EVT_PLL_FLT])
        else $error("pll fault event lost");
    // bits only fall on a w1c; a read or a quiet input leaves them set
    a_raw_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> ($past(sys_event_raw_status_ff) & ~sys_event_raw_status_ff
            & ~$past(w1c_clr)) == 7'h00)
        else $error("raw bit fell without a clear");
    a_raw_rise: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (sys_event_raw_status_ff & ~$past(sys_event_raw_status_ff)
            & ~$past(evt_in)) == 7'h00)
        else $error("raw bit rose without an event");
    a_w1c_all: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_MASKED_CLR) |=> (sys_event_raw_status_ff
            & $past(pwdata[6:0] & sys_event_mask_reg_ff & ~evt_in)) == 7'h00)
        else $error("w1c left a masked raw bit set");

    // -------------------------------------------------------------
    // interrupt checks
    // -------------------------------------------------------------
    a_irq_off: assert property (@(posedge clk) disable iff (!rst_n)
        ((sys_event_raw_status_ff & sys_event_mask_reg_ff) == 7'h00) |=> !sys_irq)
        else $error("interrupt with nothing unmasked");
    a_irq_on: assert property (@(posedge clk) disable iff (!rst_n)
        ((sys_event_raw_status_ff & sys_event_mask_reg_ff
            & ~(7'h01 << ssr_pkg::EVT_BROWNOUT)) != 7'h00) |=> sys_irq)
        else $error("unmasked event gave no interrupt");
    a_bor_irq: assert property (@(posedge clk) disable iff (!rst_n)
        (sys_event_raw_status_ff[ssr_pkg::EVT_BROWNOUT] && !brownout_reset_select_ff
            && sys_event_mask_reg_ff[ssr_pkg::EVT_BROWNOUT]) |=> sys_irq)
        else $error("brown-out interrupt missing");
    // with reset selected the brown-out must stay off the interrupt line
    a_bor_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (brownout_reset_select_ff && (sys_event_raw_status_ff & sys_event_mask_reg_ff
            & ~(7'h01 << ssr_pkg::EVT_BROWNOUT)) == 7'h00) |=> !sys_irq)
        else $error("brown-out reached interrupt with reset selected");
    a_bor_req_off: assert property (@(posedge clk) disable iff (!rst_n)
        (!brownout_reset_select_ff || !sys_event_raw_status_ff[ssr_pkg::EVT_BROWNOUT])
        |=> !brownout_reset_req)
        else $error("brown-out reset without select and event");
    a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_EVENT_MASK)
        |=> sys_event_mask_reg_ff == $past(pwdata[6:0]))
        else $error("mask register did not take write");
    a_sel_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == ssr_pkg::OFF_BROWNOUT_CTL)
        |=> brownout_reset_select_ff == $past(pwdata[ssr_pkg::BOR_SEL_BIT]))
        else $error("brown-out select did not take write");
endmodule

/* tb/test_sysctl_soft_reset_raw_irq.sv */
// Purpose: self-checking bench for the soft reset and raw event slice
// Assumes: apb access answers within the apb task's 50-cycle wait; events are pulses
// Notes:   capability inputs leave some bits absent to exercise write gating
`timescale 1ns/100ps
module test_sysctl_soft_reset_raw_irq;
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] cap1    = 32'hFFFE_FFFF;
    logic [31:0] cap2    = 32'hFFFD_FFFF;
    logic [31:0] cap4    = 32'h0000_0015;
    logic [6:0]  evt     = 7'h00;
    logic [31:0] prdata, pr0, pr1, prt, rd;
    logic        pready, pslverr, sys_irq, bor_req, err;
    int          fails     = 0;
    int          tests_run = 0;

    always #10 clk = ~clk;

    ssr_sysctl ssr_sysctl_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capability_reg_1(cap1), .capability_reg_2(cap2),
        .capability_reg_4(cap4), .pll_ready_evt(evt[6]), .current_limit_evt(evt[5]),
        .internal_osc_fault_evt(evt[4]), .main_osc_fault_evt(evt[3]),
        .regulator_unreg_evt(evt[2]), .brownout_evt(evt[1]), .pll_fault_evt(evt[0]),
        .periph_reset_0(pr0), .periph_reset_1(pr1), .port_reset(prt),
        .sys_irq(sys_irq), .brownout_reset_req(bor_req));

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is sampled high; no latency assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // registered outputs trail the bus by a cycle; margin for that
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rchk(ssr_pkg::OFF_SOFT_RESET_0, 32'h0000_0000);
        rchk(ssr_pkg::OFF_SOFT_RESET_1, 32'h0000_0000);
        rchk(ssr_pkg::OFF_PORT_RESET, 32'h0000_0000);
        rchk(ssr_pkg::OFF_RAW_STATUS, 32'h0000_0000);
        apb(1'b1, ssr_pkg::OFF_SOFT_RESET_0, 32'hFFFF_FFFF);
        rchk(ssr_pkg::OFF_SOFT_RESET_0, 32'h0010_0008);
        apb(1'b1, ssr_pkg::OFF_SOFT_RESET_1, 32'hFFFF_FFFF);
        rchk(ssr_pkg::OFF_SOFT_RESET_1, 32'h0105_0013);
        apb(1'b1, ssr_pkg::OFF_PORT_RESET, 32'hFFFF_FFFF);
        rchk(ssr_pkg::OFF_PORT_RESET, 32'h0000_0015);
        settle;
        chk(pr0, 32'h0010_0008);
        chk(pr1, 32'h0105_0013);
        chk(prt, 32'h0000_0015);
        apb(1'b1, ssr_pkg::OFF_SOFT_RESET_0, 32'h0000_0000);
        apb(1'b1, ssr_pkg::OFF_SOFT_RESET_1, 32'h0000_0000);
        apb(1'b1, ssr_pkg::OFF_PORT_RESET, 32'h0000_0000);
        settle;
        chk(pr0 | pr1 | prt, 32'h0000_0000);
        apb(1'b1, ssr_pkg::OFF_RAW_STATUS, 32'hFFFF_FFFF);
        rchk(ssr_pkg::OFF_RAW_STATUS, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            evt <= 7'h01 << i;
            @(posedge clk);
            evt <= 7'h00;
            rchk(ssr_pkg::OFF_RAW_STATUS, 32'h0000_007F >> (6 - i));
        end
        rchk(ssr_pkg::OFF_RAW_STATUS, 32'h0000_007F);
        chk({31'h0, sys_irq}, 32'h0000_0000);
        apb(1'b1, ssr_pkg::OFF_EVENT_MASK, 32'h0000_0001);
        settle;
        chk({31'h0, sys_irq}, 32'h0000_0001);
        rchk(ssr_pkg::OFF_MASKED_CLR, 32'h0000_0001);
        apb(1'b1, ssr_pkg::OFF_MASKED_CLR, 32'h0000_0001);
        rchk(ssr_pkg::OFF_RAW_STATUS, 32'h0000_007E);
        settle;
        chk({31'h0, sys_irq}, 32'h0000_0000);
        apb(1'b1, ssr_pkg::OFF_EVENT_MASK, 32'h0000_0002);
        apb(1'b1, ssr_pkg::OFF_BROWNOUT_CTL, 32'h0000_0002);
        rchk(ssr_pkg::OFF_BROWNOUT_CTL, 32'h0000_0002);
        rchk(ssr_pkg::OFF_EVENT_MASK, 32'h0000_0002);
        settle;
        chk({30'h0, sys_irq, bor_req}, 32'h0000_0001);
        apb(1'b1, ssr_pkg::OFF_BROWNOUT_CTL, 32'h0000_0000);
        settle;
        chk({30'h0, sys_irq, bor_req}, 32'h0000_0002);
        apb(1'b1, ssr_pkg::OFF_MASKED_CLR, 32'h0000_0004);
        rchk(ssr_pkg::OFF_RAW_STATUS, 32'h0000_007E);
        apb(1'b1, ssr_pkg::OFF_MASKED_CLR, 32'h0000_0002);
        rchk(ssr_pkg::OFF_RAW_STATUS, 32'h0000_007C);
        settle;
        chk({31'h0, sys_irq}, 32'h0000_0000);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        rchk(12'h0FC, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        end_of_test;
    end

    // whole run is well under a thousand cycles
    initial begin
        #200000;
        fails++;
        end_of_test;
    end
endmodule
